/* rtl/irtl_pkg.sv */
// Package with register map, field layout and timing constants of the IR block
package irtl_pkg;
	// Clock and microsecond tick
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = CLK_MHZ * TICK_US;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	// Learning carrier range
	localparam int CARR_MIN_KHZ = 10;
	localparam int CARR_MAX_KHZ = 500;
	localparam int CARR_MAX_PER = (CLK_MHZ * 1000) / CARR_MIN_KHZ;
	localparam int CARR_MIN_PER = (CLK_MHZ * 1000) / CARR_MAX_KHZ;
	localparam logic [15:0] CARR_MAX_PER_W = 16'(CARR_MAX_PER);
	localparam logic [15:0] CARR_MIN_PER_W = 16'(CARR_MIN_PER);
	// Descriptor layout and FIFO
	localparam int DUR_W = 15;
	localparam logic [14:0] DUR_MAX = 15'h7fff;
	localparam int DESC_LEVEL_BIT = 15;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CARR_HALF = 8'h04;
	localparam logic [7:0] REG_DESC = 8'h08;
	localparam logic [7:0] REG_FIFO_LVL = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] REG_LRN_INTV = 8'h18;
	localparam logic [7:0] REG_LRN_CARR = 8'h1c;
	// Control fields
	localparam int CTRL_MOD_BIT = 0;
	localparam int CTRL_SRC_LSB = 1;
	localparam int CTRL_BIT_BIT = 3;
	localparam int CTRL_LRN_BIT = 4;
	localparam logic [31:0] CTRL_RST = 32'h0;
	localparam logic [15:0] CARR_HALF_RST = 16'h0641;
	// Interrupt status bits
	localparam int IRQ_UNDER = 0;
	localparam int IRQ_INTV = 1;
	localparam int IRQ_OVER = 2;
	localparam int IRQ_W = 3;
	// Source select codes
	localparam logic [1:0] SRC_DESC = 2'h0;
	localparam logic [1:0] SRC_BIT = 2'h1;
	localparam logic [1:0] SRC_UART = 2'h2;
	typedef enum logic [1:0] {IRTL_TX_IDLE, IRTL_TX_PLAY} irtl_tx_st_t;
endpackage : irtl_pkg

/* rtl/irtl_fifo_if.sv */
// Interface between the descriptor FIFO and the transmit sequencer
`timescale 1ns/1ns
interface irtl_fifo_if;
	logic push;
	logic [15:0] wdata;
	logic full;
	logic pop;
	logic [15:0] rdata;
	logic empty;
	logic [4:0] level;
	modport fifo (input push, input wdata, input pop, output full, output rdata, output empty, output level);
	modport user (output push, output wdata, output pop, input full, input rdata, input empty, input level);
endinterface : irtl_fifo_if

/* rtl/irtl_fifo.sv */
// Descriptor FIFO holding on/off state and duration words
`timescale 1ns/1ns
module irtl_fifo
	import irtl_pkg::*;
(
	input wire logic core_clk_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset
	irtl_fifo_if.fifo f // FIFO port
);
	import irtl_pkg::*;
	typedef struct packed {
		logic [FIFO_AW-1:0] wp;
		logic [FIFO_AW-1:0] rp;
		logic [FIFO_AW:0] cnt;
	} irtl_fifo_st_t;
	irtl_fifo_st_t s_q, s_d;
	logic [15:0] mem [FIFO_DEPTH];
	logic do_push, do_pop;
	assign f.full = s_q.cnt == 5'(FIFO_DEPTH);
	assign f.empty = s_q.cnt == 5'h00;
	assign f.level = s_q.cnt;
	assign f.rdata = mem[s_q.rp];
	assign do_push = f.push && !f.full;
	assign do_pop = f.pop && !f.empty;
	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.wp = s_q.wp + 4'h1;
		end
		if (do_pop) begin
			s_d.rp = s_q.rp + 4'h1;
		end
		s_d.cnt = s_q.cnt + {4'h0, do_push} - {4'h0, do_pop};
		if (sys_rst_i) begin
			s_d = '0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		s_q <= s_d;
		if (do_push) begin
			mem[s_q.wp] <= f.wdata;
		end
	end
endmodule : irtl_fifo

/* rtl/irtl_top.sv */
// IR transmitter with descriptor FIFO and carrier, plus IR learning receiver
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module irtl_top
	import irtl_pkg::*;
(
	input wire logic core_clk_i, // System clock, 125 MHz
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic [7:0] reg_addr_i, // Register byte address
	input wire logic [31:0] reg_wdata_i, // Register write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
	input wire logic uart_txd_i, // Peripheral UART transmit line
	input wire logic ir_det_i, // IR detector pin, high when light seen
	output logic ir_tx_o, // IR emitter drive
	output logic irq_o // Level interrupt
);
	import irtl_pkg::*;

	// ==============================
	// State
	typedef struct packed {
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [15:0] carr_half;
		logic [15:0] carr_cnt;
		logic carr_ph;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic [7:0] tick_cnt;
		irtl_tx_st_t tx_st;
		logic tx_lvl;
		logic [14:0] tx_rem;
		logic ir_out;
		logic [1:0] uart_sy;
		logic [1:0] det_sy;
		logic det_prev;
		logic env;
		logic [15:0] edge_gap;
		logic [15:0] per_meas;
		logic [15:0] lrn_per;
		logic [14:0] lrn_dur;
		logic [15:0] lrn_intv;
	} irtl_st_t;
	irtl_st_t s_q, s_d;
	irtl_fifo_if fif ();

	irtl_fifo u_fifo (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.f(fif)
	);

	function automatic logic [15:0] sat_inc16(input logic [15:0] v);
		sat_inc16 = (v == 16'hffff) ? v : v + 16'h0001;
	endfunction : sat_inc16

	logic tick;
	logic wr_desc;
	logic tx_src;
	logic det_rise;
	logic env_now;
	logic [1:0] src;
	logic [IRQ_W-1:0] stat_set;

	assign tick = s_q.tick_cnt == TICK_LAST;
	assign src = s_q.ctrl[CTRL_SRC_LSB +: 2];
	assign wr_desc = reg_wr_i && reg_addr_i == REG_DESC;
	assign fif.push = wr_desc;
	assign fif.wdata = reg_wdata_i[15:0];
	assign fif.pop = (s_q.tx_st == IRTL_TX_IDLE || (tick && s_q.tx_rem == 15'h0001)) && !fif.empty
		&& src == SRC_DESC;
	assign det_rise = s_q.det_sy[1] && !s_q.det_prev;
	// Envelope: still present while edges keep coming faster than the slowest carrier
	assign env_now = s_q.det_sy[1] || (s_q.edge_gap < CARR_MAX_PER_W);

	always_comb begin
		case (src)
			SRC_DESC: tx_src = s_q.tx_st == IRTL_TX_PLAY && s_q.tx_lvl;
			SRC_BIT: tx_src = s_q.ctrl[CTRL_BIT_BIT];
			SRC_UART: tx_src = !s_q.uart_sy[1];
			default: tx_src = 1'b0;
		endcase
	end

	// ==============================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rdata = 32'h0;
		stat_set = '0;
		s_d.tick_cnt = tick ? 8'h00 : s_q.tick_cnt + 8'h01;
		s_d.uart_sy = {s_q.uart_sy[0], uart_txd_i};
		s_d.det_sy = {s_q.det_sy[0], ir_det_i};
		s_d.det_prev = s_q.det_sy[1];

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CTRL: s_d.ctrl = {27'h0, reg_wdata_i[4:0]};
				REG_CARR_HALF: s_d.carr_half = reg_wdata_i[15:0];
				REG_IRQ_MASK: s_d.mask = reg_wdata_i[IRQ_W-1:0];
				default: ;
			endcase
		end

		// Carrier generator, half period of carr_half plus one clocks
		if (s_q.carr_cnt >= s_q.carr_half) begin
			s_d.carr_cnt = 16'h0000;
			s_d.carr_ph = !s_q.carr_ph;
		end else begin
			s_d.carr_cnt = s_q.carr_cnt + 16'h0001;
		end

		// Descriptor sequencer
		case (s_q.tx_st)
			IRTL_TX_IDLE: begin
				if (fif.pop) begin
					s_d.tx_st = IRTL_TX_PLAY;
					s_d.tx_lvl = fif.rdata[DESC_LEVEL_BIT];
					s_d.tx_rem = (fif.rdata[14:0] == 15'h0) ? 15'h0001 : fif.rdata[14:0];
					s_d.tick_cnt = 8'h00;
				end
			end
			IRTL_TX_PLAY: begin
				if (tick) begin
					if (s_q.tx_rem != 15'h0001) begin
						s_d.tx_rem = s_q.tx_rem - 15'h0001;
					end else if (fif.pop) begin
						s_d.tx_lvl = fif.rdata[DESC_LEVEL_BIT];
						s_d.tx_rem = (fif.rdata[14:0] == 15'h0) ? 15'h0001 : fif.rdata[14:0];
					end else begin
						s_d.tx_st = IRTL_TX_IDLE;
						s_d.tx_lvl = 1'b0;
						if (src == SRC_DESC) begin
							stat_set[IRQ_UNDER] = 1'b1;
						end
					end
				end
				if (src != SRC_DESC) begin
					s_d.tx_st = IRTL_TX_IDLE;
				end
			end
			default: s_d.tx_st = IRTL_TX_IDLE;
		endcase

		// Output stage, carrier gated onto every on interval
		s_d.ir_out = tx_src && (!s_q.ctrl[CTRL_MOD_BIT] || s_q.carr_ph);

		// Learning receiver
		s_d.edge_gap = det_rise ? 16'h0000 : sat_inc16(s_q.edge_gap);
		if (det_rise && s_q.edge_gap >= CARR_MIN_PER_W && s_q.edge_gap < CARR_MAX_PER_W) begin
			s_d.lrn_per = s_q.edge_gap + 16'h0001;
		end
		if (s_q.ctrl[CTRL_LRN_BIT]) begin
			s_d.env = env_now;
			if (env_now != s_q.env) begin
				s_d.lrn_intv = {s_q.env, s_q.lrn_dur};
				s_d.lrn_dur = 15'h0000;
				if (s_q.stat[IRQ_INTV]) begin
					stat_set[IRQ_OVER] = 1'b1;
				end
				stat_set[IRQ_INTV] = 1'b1;
			end else if (tick && s_q.lrn_dur != DUR_MAX) begin
				s_d.lrn_dur = s_q.lrn_dur + 15'h0001;
			end
		end else begin
			s_d.env = 1'b0;
			s_d.lrn_dur = 15'h0000;
		end

		// Reads and write-one-to-clear; a new event wins over the clear
		s_d.stat = s_q.stat | stat_set;
		if (reg_wr_i && reg_addr_i == REG_IRQ_STAT) begin
			s_d.stat = (s_q.stat & ~reg_wdata_i[IRQ_W-1:0]) | stat_set;
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CTRL: s_d.rdata = s_q.ctrl;
				REG_CARR_HALF: s_d.rdata = {16'h0, s_q.carr_half};
				REG_FIFO_LVL: s_d.rdata = {26'h0, fif.full, fif.level};
				REG_IRQ_STAT: s_d.rdata = {29'h0, s_q.stat};
				REG_IRQ_MASK: s_d.rdata = {29'h0, s_q.mask};
				REG_LRN_INTV: s_d.rdata = {16'h0, s_q.lrn_intv};
				REG_LRN_CARR: s_d.rdata = {16'h0, s_q.lrn_per};
				default: s_d.rdata = 32'h0;
			endcase
		end

		if (sys_rst_i) begin
			s_d = '0;
			s_d.ctrl = CTRL_RST;
			s_d.carr_half = CARR_HALF_RST;
			// No edge seen yet, so no false envelope after reset
			s_d.edge_gap = CARR_MAX_PER_W;
			s_d.tx_st = IRTL_TX_IDLE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		s_q <= s_d;
	end

	assign reg_rdata_o = s_q.rdata;
	assign ir_tx_o = s_q.ir_out;
	assign irq_o = |(s_q.stat & s_q.mask);
endmodule : irtl_top

/* dv/irtl_chk.sv */
// Port assertions for the IR block
`timescale 1ns/1ns
module irtl_chk
	import irtl_pkg::*;
(
	input wire logic core_clk_i, // clk
	input wire logic sys_rst_i, // rst
	input wire logic [7:0] reg_addr_i, // addr
	input wire logic [31:0] reg_wdata_i, // wdata
	input wire logic reg_wr_i, // wr
	input wire logic reg_rd_i, // rd
	input wire logic [31:0] reg_rdata_o, // rdata
	input wire logic uart_txd_i, // uart
	input wire logic ir_det_i, // det
	input wire logic ir_tx_o, // tx
	input wire logic irq_o // irq
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ====
	// Register shadows and emitter run length
	logic [4:0] ctl_q;
	logic [15:0] car_q;
	logic [2:0] msk_q;
	logic tx_q;
	logic [16:0] run_q;
	logic wc;
	logic [5:0] gap_q;
	logic mg;
	assign wc = reg_wr_i && reg_addr_i == REG_CTRL;
	// Bit source on with carrier and a short half period
	assign mg = ctl_q[3:0] == 4'hb && car_q < 16'h10;
	always_ff @(posedge core_clk_i) begin
		if (wc) ctl_q <= reg_wdata_i[4:0];
		if (reg_wr_i && reg_addr_i == REG_CARR_HALF) car_q <= reg_wdata_i[15:0];
		if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) msk_q <= reg_wdata_i[2:0];
		tx_q <= ir_tx_o;
		// Top bit marks a run disturbed by a mode change
		run_q <= wc ? 17'h10000 : (ir_tx_o != tx_q) ? 17'h1 : run_q + 17'h1;
		// Cycles without an emitter change while the carrier mode holds
		gap_q <= (!mg || ir_tx_o != tx_q) ? 6'h00 : gap_q + 6'h01;
		if (sys_rst_i) begin
			ctl_q <= CTRL_RST[4:0];
			car_q <= CARR_HALF_RST;
			msk_q <= 3'h0;
			run_q <= 17'h10000;
			gap_q <= 6'h00;
		end
	end
	property p_rd_idle;
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
	property p_rd_unmap;
		reg_rd_i && reg_addr_i > REG_LRN_CARR |=> reg_rdata_o == 32'h0;
	endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
	property p_irq_off;
		(msk_q == 3'h0) [*2] |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq");
	property p_bit_src;
		(ctl_q[2:1] == SRC_BIT && !ctl_q[0]) [*4] |-> ir_tx_o == ctl_q[CTRL_BIT_BIT];
	endproperty
	a_bit_src: assert property (p_bit_src) else $error("bit source");
	property p_uart_src;
		(ctl_q[2:1] == SRC_UART && !ctl_q[0] && $stable(uart_txd_i)) [*4] |-> ir_tx_o != uart_txd_i;
	endproperty
	a_uart_src: assert property (p_uart_src) else $error("uart source");
	property p_mod_off;
		(ctl_q[2:1] == SRC_BIT && ctl_q[0] && !ctl_q[3]) [*4] |-> !ir_tx_o;
	endproperty
	a_mod_off: assert property (p_mod_off) else $error("carrier while off");
	property p_mod_gate;
		mg |-> gap_q < 6'h28;
	endproperty
	a_mod_gate: assert property (p_mod_gate) else $error("no carrier");
	property p_fifo_run;
		tx_q && !ir_tx_o && ctl_q[2:0] == 3'h0 && !run_q[16] |-> run_q % TICK_CYC == 0;
	endproperty
	a_fifo_run: assert property (p_fifo_run) else $error("on time not whole us");
endmodule : irtl_chk

/* dv/irtl_ir_model.sv */
// Behavioural IR detector feeding the learning input
`timescale 1ns/1ns
module irtl_ir_model (
	input wire logic core_clk_i, // clk
	output logic det_o // high while light is seen
);
	initial det_o = 1'b0;
	// n periods, h clocks lit then h dark
	task burst(input int n, input int h);
		repeat (n) begin
			det_o <= 1'b1;
			repeat (h) @(posedge core_clk_i);
			det_o <= 1'b0;
			repeat (h) @(posedge core_clk_i);
		end
	endtask : burst
endmodule : irtl_ir_model

/* dv/irtl_top_bench.sv */
// Self-checking bench for the IR block
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("Error %0t %h %h", $time, g, e); end end
module irtl_top_bench;
	import irtl_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic uart_txd_i = 1'b1;
	logic [31:0] reg_rdata_o, d, got, want;
	logic ir_det_i, ir_tx_o, irq_o, tx;
	logic rd_q = 1'b0;
	logic [31:0] exp_q[$], msk_q[$];
	int num_errors = 0;
	int checked = 0;
	int n;
	irtl_top DUT (.*);
	irtl_ir_model det (.core_clk_i(core_clk_i), .det_o(ir_det_i));
	initial begin
		forever #4 core_clk_i = ~core_clk_i;
	end
	// ====
	// k: 2 write, 1 read expecting v under m, 0 idle
	task bus(input logic [1:0] k, input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		reg_wr_i <= k[1];
		reg_rd_i <= k[0];
		reg_addr_i <= a;
		reg_wdata_i <= v;
		if (k[0]) begin
			exp_q.push_back(v & m);
			msk_q.push_back(m);
		end
		@(posedge core_clk_i);
	endtask : bus
	task clk(input int c);
		repeat (c) @(posedge core_clk_i);
	endtask : clk
	task run(input logic lv);
		n = 0;
		while (ir_tx_o === lv && n < 9000) begin
			n++;
			@(posedge core_clk_i);
		end
	endtask : run
	task close_out;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	always @(posedge core_clk_i) begin
		if (rd_q) begin
			want = exp_q.pop_front();
			got = reg_rdata_o & msk_q.pop_front();
			`CHK(got, want)
		end
		rd_q <= reg_rd_i;
	end
	initial begin
		clk(90000);
		num_errors++;
		close_out();
	end
	initial begin
		n = $urandom(32'hfbd4cb4d);
		clk(8);
		sys_rst_i <= 1'b0;
		clk(1);
		bus(1, REG_CTRL, CTRL_RST, '1);
		bus(1, REG_CARR_HALF, 32'(CARR_HALF_RST), '1);
		bus(1, REG_FIFO_LVL, 0, '1);
		bus(1, 8'h20, 32'h0, '1);
		d = $urandom & 32'hffff;
		bus(2, REG_CARR_HALF, d, 0);
		bus(1, REG_CARR_HALF, d, 32'hffff);
		bus(2, REG_CARR_HALF, 3, 0);
		for (int i = 0; i < 4; i++) begin
			bus(2, REG_CTRL, {28'h0, i[1], SRC_BIT, i[0]}, 0);
			bus(0, 0, 0, 0);
			clk(10);
			n = 0;
			tx = ir_tx_o;
			repeat (32) begin
				@(posedge core_clk_i);
				n += int'(ir_tx_o !== tx);
				tx = ir_tx_o;
			end
			`CHK(n, (i == 3) ? 8 : 0)
			`CHK(ir_tx_o | (i == 3), i[1])
		end
		$display("end regs and bit");
		bus(2, REG_CTRL, {29'h0, SRC_UART, 1'b0}, 0);
		bus(0, 0, 0, 0);
		repeat (16) begin
			uart_txd_i <= 1'($urandom);
			clk(6);
			`CHK(ir_tx_o, !uart_txd_i)
		end
		uart_txd_i <= 1'b1;
		bus(2, REG_CTRL, {29'h0, SRC_BIT, 1'b0}, 0);
		bus(2, REG_IRQ_MASK, 1, 0);
		bus(2, REG_DESC, 32'h8003, 0);
		bus(2, REG_DESC, 32'h0002, 0);
		bus(2, REG_DESC, 32'h8001, 0);
		bus(2, REG_CTRL, 0, 0);
		bus(0, 0, 0, 0);
		run(0);
		run(1);
		`CHK(n, 3 * TICK_CYC)
		run(0);
		`CHK(n, 2 * TICK_CYC)
		run(1);
		`CHK(n, TICK_CYC)
		clk(4);
		`CHK(ir_tx_o, 1'b0)
		`CHK(irq_o, 1'b1)
		bus(1, REG_IRQ_STAT, 1, 7);
		bus(2, REG_IRQ_STAT, 7, 0);
		bus(1, REG_IRQ_STAT, 0, 7);
		`CHK(irq_o, 1'b0)
		bus(2, REG_CTRL, {29'h0, SRC_BIT, 1'b0}, 0);
		repeat (FIFO_DEPTH + 1) bus(2, REG_DESC, 32'h8001, 0);
		bus(1, REG_FIFO_LVL, 32'h30, 32'h3f);
		bus(2, REG_CTRL, 0, 0);
		bus(0, 0, 0, 0);
		run(0);
		run(1);
		`CHK(n, FIFO_DEPTH * TICK_CYC)
		$display("end transmit");
		bus(2, REG_IRQ_STAT, 7, 0);
		bus(2, REG_CTRL, 32'h12, 0);
		bus(0, 0, 0, 0);
		det.burst(10, 500);
		clk(13000);
		bus(1, REG_LRN_CARR, 1000, 32'hffff);
		bus(1, REG_LRN_INTV, 32'h8000, 32'h8000);
		bus(1, REG_IRQ_STAT, 2, 2);
		bus(0, 0, 0, 0);
		det.burst(1, 5000);
		bus(1, REG_LRN_INTV, 0, 32'h8000);
		bus(0, 0, 0, 0);
		clk(9000);
		bus(1, REG_LRN_INTV, 32'h8000, 32'h8000);
		bus(0, 0, 0, 0);
		clk(2);
		$display("end learning");
		close_out();
	end
endmodule : irtl_top_bench
bind irtl_top irtl_chk u_chk (.*);
